// ### ppsra_defs.svh
// Purpose: constants for the port suspend register access block
// Assumes: register and packet field codes as used by the packet decoder
// Notes: times in ns; PPSRA_RESUME_WAIT is counted in ref_clk cycles at 50 MHz
`ifndef PPSRA_DEFS_SVH
`define PPSRA_DEFS_SVH
`define PPSRA_TYPE_READ 6'h00
`define PPSRA_TYPE_WRITE 6'h01
`define PPSRA_TYPE_RESUME 6'h02
`define PPSRA_TYPE_RESP 6'h3F
`define PPSRA_PORT_LAST 5'h1A
`define PPSRA_PORT_NODE 5'h1F
`define PPSRA_REG_STAT_A 3'h0
`define PPSRA_REG_STAT_B 3'h1
`define PPSRA_REG_CTL_SET 3'h2
`define PPSRA_REG_CTL_CLR 3'h3
`define PPSRA_RESUME_PORT 5'h00
`define PPSRA_RESUME_REG 3'h3
`define PPSRA_RESUME_VAL 8'h02
`define PPSRA_BIT_INT_EN 7
`define PPSRA_BIT_SUSPEND 6
`define PPSRA_BIT_DISABLE 5
`define PPSRA_BIT_TOKEN 4
`define PPSRA_BIT_FAULT 3
`define PPSRA_CTL_RW_MASK 8'hB8
`define PPSRA_CTL_RESET 8'h40
`define PPSRA_RESET_DETECT_NS 1000
`define PPSRA_CLK_NS 20
`define PPSRA_RESUME_PERIODS 5
`define PPSRA_RESUME_WAIT ((`PPSRA_RESUME_PERIODS * `PPSRA_RESET_DETECT_NS) / `PPSRA_CLK_NS)
`endif

// ### ppsra_pkg.sv
// Purpose: types for the port suspend register access block
// Assumes: nothing beyond the defs header
// Notes: packet layout matches the extended register packet
package ppsra_pkg;
  typedef struct packed {
    logic [5:0] node_address_field;
    logic [5:0] op_type;
    logic [4:0] port_sel;
    logic [2:0] reg_sel;
    logic [7:0] value;
  } ppsra_pkt_t;

  typedef enum logic [1:0] {
    PPSRA_IDLE = 2'b00,
    PPSRA_WAIT = 2'b01,
    PPSRA_RESET = 2'b10
  } ppsra_resume_state_t;
endpackage

// ### ppsra_top.sv
// Purpose: per-port register access with suspend and resume selection
// Assumes: packets arrive as one-cycle strobes, synchronous to ref_clk
// Notes: analogue sensing arrives as per-port levels already filtered
`timescale 1ns/1ps
`include "ppsra_defs.svh"
module ppsra_top #(
  parameter int NPORTS = 4,
  parameter logic [5:0] NODE_ADDR = 6'h00,
  parameter int RESUME_WAIT = `PPSRA_RESUME_WAIT
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pkt_valid,
  input wire ppsra_pkg::ppsra_pkt_t pkt_in,
  input wire logic [NPORTS-1:0] cable_bias_level,
  input wire logic [NPORTS-1:0] port_connected_sense,
  input wire logic [NPORTS-1:0] port_resume_detect,
  input wire logic [NPORTS-1:0][7:0] port_line_status,
  input wire logic [NPORTS-1:0][7:0] port_speed_status,
  input wire logic [7:0][7:0] node_regs,
  output logic resp_valid,
  output ppsra_pkg::ppsra_pkt_t resp_out,
  output logic [NPORTS-1:0] suspend_notify,
  output logic [NPORTS-1:0] resume_event,
  output logic [NPORTS-1:0] port_bus_reset,
  output logic [NPORTS-1:0] selfid_disconnected,
  output logic [NPORTS-1:0] port_connected
);

  logic [NPORTS-1:0][7:0] ctl;
  logic [NPORTS-1:0] con_q;
  logic [NPORTS-1:0] resume_init;
  ppsra_pkg::ppsra_resume_state_t rs_state;
  logic [31:0] rs_count;
  logic [NPORTS-1:0] rs_targets;

  // decode of the incoming packet; unknown types fall through as no-ops
  logic is_read;
  logic is_write;
  logic is_resume;
  logic port_ok;
  logic node_sel;
  assign is_read = pkt_valid && (pkt_in.op_type == `PPSRA_TYPE_READ);
  assign is_write = pkt_valid && (pkt_in.op_type == `PPSRA_TYPE_WRITE);
  assign is_resume = pkt_valid && (pkt_in.op_type == `PPSRA_TYPE_RESUME)
    && (pkt_in.port_sel == `PPSRA_RESUME_PORT) && (pkt_in.reg_sel == `PPSRA_RESUME_REG)
    && (pkt_in.value == `PPSRA_RESUME_VAL);
  assign port_ok = (pkt_in.port_sel <= `PPSRA_PORT_LAST)
    && (32'(pkt_in.port_sel) < NPORTS);
  assign node_sel = (pkt_in.port_sel == `PPSRA_PORT_NODE);

  // read-back value shares one mux for the response
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (node_sel) begin
      rd_val = node_regs[pkt_in.reg_sel];
    end else if (port_ok) begin
      case (pkt_in.reg_sel)
        `PPSRA_REG_STAT_A: rd_val = port_line_status[pkt_in.port_sel];
        `PPSRA_REG_STAT_B: rd_val = port_speed_status[pkt_in.port_sel];
        `PPSRA_REG_CTL_SET: rd_val = ctl[pkt_in.port_sel];
        `PPSRA_REG_CTL_CLR: rd_val = ctl[pkt_in.port_sel];
        default: rd_val = 8'h00;
      endcase
    end
  end

  // response is the current contents with the write's masked bits applied; the bias gating of disable and suspend is not reflected
  logic [7:0] resp_val;
  always_comb begin
    resp_val = rd_val;
    if (is_write && port_ok) begin
      if (pkt_in.reg_sel == `PPSRA_REG_CTL_SET) begin
        resp_val = rd_val | (pkt_in.value & `PPSRA_CTL_RW_MASK);
      end else if (pkt_in.reg_sel == `PPSRA_REG_CTL_CLR) begin
        resp_val = rd_val & ~(pkt_in.value & `PPSRA_CTL_RW_MASK);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
      resp_out <= '0;
    end else begin
      resp_valid <= is_read || is_write;
      if (is_read || is_write) begin
        resp_out.node_address_field <= NODE_ADDR;
        resp_out.op_type <= `PPSRA_TYPE_RESP;
        resp_out.port_sel <= pkt_in.port_sel;
        resp_out.reg_sel <= pkt_in.reg_sel;
        resp_out.value <= resp_val;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      logic wr_here;
      logic sel_susp;
      logic sel_resume;
      logic new_con;
      assign wr_here = is_write && port_ok && (32'(pkt_in.port_sel) == g);
      // only control offsets accept writes; status stays read-only
      assign sel_susp = wr_here && (pkt_in.reg_sel == `PPSRA_REG_CTL_SET)
        && pkt_in.value[`PPSRA_BIT_SUSPEND] && !ctl[g][`PPSRA_BIT_DISABLE]
        && !ctl[g][`PPSRA_BIT_FAULT];
      assign new_con = port_connected_sense[g] && !con_q[g];
      assign sel_resume = ctl[g][`PPSRA_BIT_SUSPEND] && !ctl[g][`PPSRA_BIT_FAULT] && (
        (wr_here && (pkt_in.reg_sel == `PPSRA_REG_CTL_CLR)
          && pkt_in.value[`PPSRA_BIT_SUSPEND])
        || (is_resume && con_q[g])
        || (con_q[g] && (|(port_resume_detect & con_q & ~(NPORTS'(1) << g))))
        || new_con);

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          ctl[g] <= `PPSRA_CTL_RESET;
        end else begin
          // suspend bit tracks bias only; writes cannot move it
          ctl[g][`PPSRA_BIT_SUSPEND] <= !cable_bias_level[g];
          if (!cable_bias_level[g]) begin
            ctl[g][`PPSRA_BIT_DISABLE] <= 1'b0;
          end
          if (wr_here && (pkt_in.reg_sel == `PPSRA_REG_CTL_SET)) begin
            if (pkt_in.value[`PPSRA_BIT_INT_EN]) ctl[g][`PPSRA_BIT_INT_EN] <= 1'b1;
            if (pkt_in.value[`PPSRA_BIT_TOKEN]) ctl[g][`PPSRA_BIT_TOKEN] <= 1'b1;
            if (pkt_in.value[`PPSRA_BIT_FAULT]) ctl[g][`PPSRA_BIT_FAULT] <= 1'b1;
            if (pkt_in.value[`PPSRA_BIT_DISABLE] && cable_bias_level[g]) begin
              ctl[g][`PPSRA_BIT_DISABLE] <= 1'b1;
            end
          end else if (wr_here && (pkt_in.reg_sel == `PPSRA_REG_CTL_CLR)) begin
            if (pkt_in.value[`PPSRA_BIT_INT_EN]) ctl[g][`PPSRA_BIT_INT_EN] <= 1'b0;
            if (pkt_in.value[`PPSRA_BIT_TOKEN]) ctl[g][`PPSRA_BIT_TOKEN] <= 1'b0;
            if (pkt_in.value[`PPSRA_BIT_FAULT]) ctl[g][`PPSRA_BIT_FAULT] <= 1'b0;
            if (pkt_in.value[`PPSRA_BIT_DISABLE]) ctl[g][`PPSRA_BIT_DISABLE] <= 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          con_q[g] <= 1'b0;
        end else begin
          con_q[g] <= port_connected_sense[g];
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          suspend_notify[g] <= 1'b0;
          resume_event[g] <= 1'b0;
          resume_init[g] <= 1'b0;
        end else begin
          suspend_notify[g] <= sel_susp;
          resume_event[g] <= sel_resume;
          // cleared once the reset toward initiators is issued
          if (sel_resume) begin
            resume_init[g] <= 1'b1;
          end else if (rs_state == ppsra_pkg::PPSRA_RESET) begin
            resume_init[g] <= 1'b0;
          end
        end
      end

      assign selfid_disconnected[g] = !con_q[g] || ctl[g][`PPSRA_BIT_DISABLE]
        || ctl[g][`PPSRA_BIT_SUSPEND];
      assign rs_targets[g] = resume_init[g]
        || (con_q[g] && !ctl[g][`PPSRA_BIT_SUSPEND] && !ctl[g][`PPSRA_BIT_DISABLE]);
    end
  endgenerate

  assign port_connected = con_q;

  // resume-packet delay; count is a parameter so simulation can shorten it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rs_state <= ppsra_pkg::PPSRA_IDLE;
      rs_count <= 32'h0000_0000;
    end else begin
      case (rs_state)
        ppsra_pkg::PPSRA_IDLE: begin
          rs_count <= 32'h0000_0000;
          if (is_resume) rs_state <= ppsra_pkg::PPSRA_WAIT;
        end
        ppsra_pkg::PPSRA_WAIT: begin
          rs_count <= rs_count + 32'h0000_0001;
          if (rs_count >= 32'(RESUME_WAIT - 1)) rs_state <= ppsra_pkg::PPSRA_RESET;
        end
        ppsra_pkg::PPSRA_RESET: rs_state <= ppsra_pkg::PPSRA_IDLE;
        default: rs_state <= ppsra_pkg::PPSRA_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_bus_reset <= '0;
    end else begin
      port_bus_reset <= (rs_state == ppsra_pkg::PPSRA_RESET) ? rs_targets : '0;
    end
  end
endmodule

// ### ppsra_peer.sv
// Purpose: far-side peer ports for the register access bench
// Assumes: plug says which cables are attached
// Notes: a notified peer drops its bias until woken or unplugged
`timescale 1ns/1ps
module ppsra_peer #(
  parameter int N = 4
) (
  input wire logic ref_clk,
  input wire logic [N-1:0] plug,
  input wire logic [N-1:0] suspend_notify,
  input wire logic [N-1:0] resume_event,
  output logic [N-1:0] cable_bias_level,
  output logic [N-1:0] port_connected_sense
);
  logic [N-1:0] asleep = '0;
  always @(posedge ref_clk) begin
    asleep <= (asleep | suspend_notify) & ~resume_event & plug;
  end
  assign cable_bias_level = plug & ~asleep;
  assign port_connected_sense = plug;
endmodule

// ### ppsra_top_chk.sv
// Purpose: port-level checks for ppsra_top
// Assumes: one clock, async active-low reset
// Notes: bound into every instance
`timescale 1ns/1ps
module ppsra_chk #(
  parameter int NPORTS = 4,
  parameter int RESUME_WAIT = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pkt_valid,
  input wire ppsra_pkg::ppsra_pkt_t pkt_in,
  input wire logic resp_valid,
  input wire ppsra_pkg::ppsra_pkt_t resp_out,
  input wire logic [NPORTS-1:0] suspend_notify,
  input wire logic [NPORTS-1:0] port_bus_reset,
  input wire logic [NPORTS-1:0] selfid_disconnected,
  input wire logic [NPORTS-1:0] port_connected,
  input wire logic [NPORTS-1:0] port_connected_sense
);
  localparam int RW_HI = RESUME_WAIT + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire rw_req = pkt_valid && pkt_in.op_type inside {6'h00, 6'h01};
  wire bad_loc = pkt_in.port_sel inside {[5'h1B:5'h1E]}
    || (pkt_in.port_sel < 5'h1F && pkt_in.reg_sel[2]);
  wire notify_req = pkt_valid && pkt_in.op_type == 6'h01 && pkt_in.reg_sel == 3'h2 && pkt_in.value[6];
  sequence resume_pkt;
    pkt_valid && pkt_in.op_type == 6'h02 && pkt_in.port_sel == 5'h00
      && pkt_in.reg_sel == 3'h3 && pkt_in.value == 8'h02 && |port_connected;
  endsequence
  sequence quiet_reset;
    (port_bus_reset == '0) [*3];
  endsequence
  a_rw_answered: assert property (rw_req |=> resp_valid && resp_out.op_type == 6'h3F)
    else $error("read or write left unanswered");
  a_resp_echo: assert property (rw_req |=> resp_out.port_sel == $past(pkt_in.port_sel))
    else $error("response port not echoed");
  a_other_quiet: assert property (pkt_valid && !rw_req |=> !resp_valid)
    else $error("response to a non read or write packet");
  a_invalid_zero: assert property (rw_req && bad_loc |=> resp_out.value == 8'h00)
    else $error("invalid location answered nonzero");
  a_selfid_unconn: assert property ((~port_connected & ~selfid_disconnected) == '0)
    else $error("unconnected port reported connected");
  a_conn_tracks: assert property ($past(nrst) |-> port_connected == $past(port_connected_sense))
    else $error("connected flag does not follow sense");
  a_notify_cause: assert property (|suspend_notify |-> $past(notify_req))
    else $error("suspend notify without set-control write");
  a_reset_waits: assert property (resume_pkt |=> quiet_reset)
    else $error("bus reset too early after resume");
  a_reset_comes: assert property (resume_pkt |-> ##[RESUME_WAIT:RW_HI] |port_bus_reset)
    else $error("bus reset missing after resume");
endmodule
bind ppsra_top ppsra_chk #(.NPORTS(NPORTS), .RESUME_WAIT(RESUME_WAIT)) u_ppsra_chk (
  .ref_clk(ref_clk), .nrst(nrst), .pkt_valid(pkt_valid), .pkt_in(pkt_in),
  .resp_valid(resp_valid), .resp_out(resp_out), .suspend_notify(suspend_notify),
  .port_bus_reset(port_bus_reset), .selfid_disconnected(selfid_disconnected),
  .port_connected(port_connected), .port_connected_sense(port_connected_sense));

// ### tb_ppsra_top.sv
// Purpose: self-checking bench for ppsra_top
// Assumes: inputs change at the falling edge
// Notes: short resume wait keeps the run brief
`timescale 1ns/1ps
module tb_ppsra_top;
  localparam int N = 4;
  localparam int RW = 4;
  logic ref_clk = 0, nrst = 0, pkt_valid = 0, seen;
  ppsra_pkg::ppsra_pkt_t pkt_in = '0, resp_out;
  logic resp_valid;
  logic [N-1:0] plug = 4'h3, bias, sense, notify, resume, bus_reset, selfid, conn;
  logic [N-1:0][7:0] stat_a = 32'h1122_3344, stat_b = 32'h5566_7788;
  logic [7:0][7:0] node_regs = 64'h0123_4567_89AB_CDEF;
  logic [7:0] got;
  logic rv_seen;
  logic [N-1:0] ntf_seen, res_seen, rdet = '0;
  int failures = 0, comparisons = 0, n;
  always #10 ref_clk = ~ref_clk;
  ppsra_top #(.NPORTS(N), .RESUME_WAIT(RW)) u_ppsra_top (.ref_clk(ref_clk), .nrst(nrst),
    .pkt_valid(pkt_valid), .pkt_in(pkt_in), .cable_bias_level(bias),
    .port_connected_sense(sense), .port_resume_detect(rdet), .port_line_status(stat_a),
    .port_speed_status(stat_b), .node_regs(node_regs), .resp_valid(resp_valid),
    .resp_out(resp_out), .suspend_notify(notify), .resume_event(resume),
    .port_bus_reset(bus_reset), .selfid_disconnected(selfid), .port_connected(conn));
  ppsra_peer #(.N(N)) u_ppsra_peer (.ref_clk(ref_clk), .plug(plug), .suspend_notify(notify),
    .resume_event(resume), .cable_bias_level(bias), .port_connected_sense(sense));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] val);
    comparisons++;
    if (val !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, val);
    end
  endtask
  // one packet, answer and pulses sampled one cycle later; a spare cycle keeps
  // pkt_valid from being lowered and raised in one time step
  task automatic xfer(input logic [5:0] op, input logic [4:0] port, input logic [2:0] sel,
      input logic [7:0] val);
    pkt_in = {6'h00, op, port, sel, val};
    pkt_valid = 1'b1;
    @(negedge ref_clk);
    got = resp_valid ? resp_out.value : 8'hxx;
    rv_seen = resp_valid;
    ntf_seen = notify;
    res_seen = resume;
    pkt_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic s_reset_vals();
    xfer(6'h00, 5'h02, 3'h2, 8'h00);
    chk("unplugged set view", 8'h40, got);
    xfer(6'h00, 5'h02, 3'h3, 8'h00);
    chk("unplugged clear view", 8'h40, got);
  endtask
  task automatic s_masks();
    xfer(6'h01, 5'h00, 3'h2, 8'h97);
    chk("set mask", 8'h90, got);
    xfer(6'h01, 5'h00, 3'h3, 8'h10);
    chk("clear mask", 8'h80, got);
    xfer(6'h01, 5'h00, 3'h2, 8'h20);
    chk("disable set", 8'hA0, got);
    chk("disabled selfid", 8'h01, {7'h00, selfid[0]});
    xfer(6'h01, 5'h00, 3'h3, 8'hA0);
    chk("all clear", 8'h00, got);
  endtask
  task automatic s_space();
    xfer(6'h01, 5'h00, 3'h0, 8'hFF);
    xfer(6'h00, 5'h00, 3'h0, 8'h00);
    chk("line status", 8'h44, got);
    xfer(6'h00, 5'h01, 3'h1, 8'h00);
    chk("speed status", 8'h77, got);
    xfer(6'h00, 5'h1C, 3'h2, 8'h00);
    chk("reserved port", 8'h00, got);
    xfer(6'h00, 5'h00, 3'h5, 8'h00);
    chk("reserved reg", 8'h00, got);
    xfer(6'h01, 5'h1F, 3'h3, 8'hFF);
    chk("node reg", 8'h89, got);
    xfer(6'h05, 5'h00, 3'h2, 8'hFF);
    chk("stray answer", 8'h00, {7'h00, rv_seen});
    xfer(6'h00, 5'h00, 3'h2, 8'h00);
    chk("stray write", 8'h00, got);
  endtask
  task automatic s_suspend();
    xfer(6'h01, 5'h01, 3'h2, 8'h40);
    chk("suspend notify", 8'h02, {4'h0, ntf_seen});
    repeat (3) @(negedge ref_clk);
    xfer(6'h00, 5'h01, 3'h3, 8'h00);
    chk("suspended ctl", 8'h40, got);
    chk("suspended selfid", 8'h01, {7'h00, selfid[1]});
  endtask
  task automatic s_replug(input logic p);
    plug[1] = p;
    seen = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      seen |= resume[1];
    end
    chk("resume on plug change", {7'h00, p}, {7'h00, seen});
    chk("connected flag", {7'h00, p}, {7'h00, conn[1]});
  endtask
  task automatic s_resume();
    xfer(6'h02, 5'h00, 3'h3, 8'h02);
    chk("resume fanout", 8'h02, {4'h0, res_seen});
    for (n = 1; n < 12 && bus_reset == '0; n++) @(negedge ref_clk);
    chk("reset delay", 8'h01, {7'h00, n == RW + 1});
    if (n == 12) results();
    chk("reset ports", 8'h03, {4'h0, bus_reset});
  endtask
  task automatic s_forward();
    xfer(6'h01, 5'h00, 3'h2, 8'h40);
    xfer(6'h01, 5'h01, 3'h2, 8'h40);
    repeat (3) @(negedge ref_clk);
    rdet = 4'h1;
    @(negedge ref_clk);
    rdet = 4'h0;
    chk("resume forward", 8'h02, {4'h0, resume});
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    s_reset_vals();
    s_masks();
    s_space();
    s_suspend();
    s_replug(1'b0);
    s_replug(1'b1);
    s_suspend();
    s_resume();
    s_forward();
    results();
  end
endmodule
